// File: kli_pkg.sv
// Package for the keypad level interrupt block: SFR offsets, widths, resets.
// Assumes an 8-bit SFR bus with 8-bit addresses, as seen by the CPU core.
package kli_pkg;
    localparam int unsigned KLI_LINES = 8;
    localparam int unsigned KLI_AW    = 8;

    typedef logic [KLI_LINES-1:0] kli_byte_t;
    typedef logic [KLI_AW-1:0]    kli_addr_t;

    localparam kli_addr_t ADDR_LEVEL_SELECT = 8'h9c;
    localparam kli_addr_t ADDR_LINE_ENABLE  = 8'h9d;
    localparam kli_addr_t ADDR_DETECT_FLAGS = 8'h9e;

    localparam kli_byte_t RST_LEVEL_SELECT  = 8'h00;
    localparam kli_byte_t RST_LINE_ENABLE   = 8'h00;
    localparam kli_byte_t RST_DETECT_FLAGS  = 8'h00;
    localparam kli_byte_t RST_RDATA         = 8'h00;
endpackage

// File: kli_line_detect.sv
// One set of per-line level comparators for the keypad port.
// Assumes port inputs already synchronous to the core clock.
module kli_line_detect
    import kli_pkg::*;
(
    input  wire kli_pkg::kli_byte_t i_port,
    input  wire kli_pkg::kli_byte_t i_level_select,
    output kli_pkg::kli_byte_t      o_match
);
    // Select low: match on 0; select high: match on 1
    assign o_match = ~(i_port ^ i_level_select);
endmodule

// File: kli_top.sv
// Keypad level interrupt block: three SFRs, eight level detectors, one request.
// Assumes the SFR bus read strobe lasts one cycle per CPU read access.
//
// Summary of operation
// - Each line sets its flag while it shows its selected level.
// - A set flag raises the request only when its enable bit is one.
// - Reading the flag register returns the flags and clears them.
// - Enable zero leaves the pin ordinary I/O; one lets it interrupt.
// - Level select zero detects low level; one detects high level.
// - Flag, enable and level select registers reset to zero.
// - Bit n of each register belongs to port line n, all independent.
// - Line requests merge into one interrupt, gated by a global enable.
// - A detection on an enabled line wakes the core from idle or power-down.
module kli_top
    import kli_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic               i_rst,
    input  wire kli_pkg::kli_byte_t i_keypad_port,
    input  wire kli_pkg::kli_addr_t i_sfr_addr,
    input  wire logic               i_sfr_wr,
    input  wire kli_pkg::kli_byte_t i_sfr_wdata,
    input  wire logic               i_sfr_rd,
    input  wire logic               i_keypad_global_irq_enable,
    output kli_pkg::kli_byte_t      o_sfr_rdata,
    output logic                    o_keypad_irq_request,
    output logic                    o_wakeup,
    output kli_pkg::kli_byte_t      o_keypad_line_enable
);
    import kli_pkg::*;

    kli_byte_t level_select_r;
    kli_byte_t line_enable_r;
    kli_byte_t detect_flags_r;
    kli_byte_t detect_flags_nxt;
    kli_byte_t rdata_r;
    kli_byte_t rdata_nxt;
    kli_byte_t match;
    logic      flags_read;

    kli_line_detect u_detect (
        .i_port         (i_keypad_port),
        .i_level_select (level_select_r),
        .o_match        (match)
    );

    // One decode used by writes and the read clear; the read mux decodes with its own case
    function automatic logic addr_hit(kli_addr_t addr, kli_addr_t reg_addr);
        return addr == reg_addr;
    endfunction

    assign flags_read = i_sfr_rd && addr_hit(i_sfr_addr, ADDR_DETECT_FLAGS);

    // Config registers
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            level_select_r <= RST_LEVEL_SELECT;
            line_enable_r  <= RST_LINE_ENABLE;
        end
        else if (i_sfr_wr)
        begin
            if (addr_hit(i_sfr_addr, ADDR_LEVEL_SELECT))
                level_select_r <= i_sfr_wdata;
            if (addr_hit(i_sfr_addr, ADDR_LINE_ENABLE))
                line_enable_r <= i_sfr_wdata;
        end
    end

    // Flags are read-clear only; writes are ignored
    always_comb
    begin
        detect_flags_nxt = detect_flags_r;
        if (flags_read)
            detect_flags_nxt = '0;
        // Set after clear so a same-cycle detection survives
        detect_flags_nxt = detect_flags_nxt | match;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            detect_flags_r <= RST_DETECT_FLAGS;
        else
            detect_flags_r <= detect_flags_nxt;
    end

    // Read data registered; flags returned as they were before the clear
    always_comb
    begin
        case (i_sfr_addr)
            ADDR_LEVEL_SELECT: rdata_nxt = level_select_r;
            ADDR_LINE_ENABLE:  rdata_nxt = line_enable_r;
            ADDR_DETECT_FLAGS: rdata_nxt = detect_flags_r;
            default:           rdata_nxt = RST_RDATA;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            rdata_r <= RST_RDATA;
        else if (i_sfr_rd)
            rdata_r <= rdata_nxt;
    end

    assign o_sfr_rdata          = rdata_r;
    // Pad logic uses this to keep disabled lines as plain I/O
    assign o_keypad_line_enable = line_enable_r;
    // Masked flags OR together onto the shared vector
    assign o_keypad_irq_request = i_keypad_global_irq_enable &&
        |(detect_flags_r & line_enable_r);
    // Wake is ungated by the global enable so power-down exit still works
    assign o_wakeup = |(detect_flags_r & line_enable_r);
endmodule

// File: kli_top_properties.sv
// Port checker for kli_top, bound below; sync reset.
module kli_chk import kli_pkg::*; (
    input wire logic i_clk, i_rst, i_sfr_wr, o_wakeup,
    input wire logic i_keypad_global_irq_enable, o_keypad_irq_request,
    input wire kli_pkg::kli_addr_t i_sfr_addr,
    input wire logic i_sfr_rd,
    input wire kli_pkg::kli_byte_t o_sfr_rdata,
    input wire kli_pkg::kli_byte_t i_sfr_wdata, o_keypad_line_enable);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_en; i_sfr_addr == ADDR_LINE_ENABLE; endsequence
    property p_wr; i_sfr_wr ##0 s_en |=>
        o_keypad_line_enable == $past(i_sfr_wdata); endproperty
    a_wr: assert property (p_wr) else $error("wr");
    property p_keep; !i_sfr_wr |=> $stable(o_keypad_line_enable); endproperty
    a_keep: assert property (p_keep) else $error("keep");
    property p_irq; o_keypad_irq_request ==
        (o_wakeup && i_keypad_global_irq_enable); endproperty
    a_irq: assert property (p_irq) else $error("irq");
    property p_off; o_keypad_line_enable == 0 |-> !o_wakeup; endproperty
    a_off: assert property (p_off) else $error("off");
    property p_rst; disable iff (1'b0) i_rst |=> !o_wakeup; endproperty
    a_rst: assert property (p_rst) else $error("rst");
    sequence s_rd; i_sfr_rd; endsequence
    sequence s_unmapped; i_sfr_addr < ADDR_LEVEL_SELECT ||
        i_sfr_addr > ADDR_DETECT_FLAGS; endsequence
    property p_hold; !i_sfr_rd |=> $stable(o_sfr_rdata); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_rd0; disable iff (1'b0) i_rst |=> o_sfr_rdata == 8'h00;
    endproperty
    a_rd0: assert property (p_rd0) else $error("rd0");
    property p_unm; s_rd ##0 s_unmapped |=> o_sfr_rdata == 8'h00;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped");
endmodule
bind kli_top kli_chk chk_u (.*);

// File: kli_keys.sv
// Keypad lines: presses from the bench, one flop late.
module kli_keys import kli_pkg::*; (input wire logic i_clk,
    input wire kli_pkg::kli_byte_t i_press,
    output kli_pkg::kli_byte_t o_lines);
    timeunit 1ns / 1ps;
    always_ff @(posedge i_clk) o_lines <= i_press;
endmodule

// File: test_keypad_level_interrupt.sv
// Random SFR traffic on kli_top against an integer model.
module test_keypad_level_interrupt;
    timeunit 1ns / 1ps;
    import kli_pkg::*;
    logic i_clk = 0, i_rst = 1, i_sfr_wr = 0, i_sfr_rd = 0, o_wakeup;
    logic i_keypad_global_irq_enable = 0, o_keypad_irq_request;
    kli_byte_t i_sfr_wdata = 0, press = 0, i_keypad_port, o_sfr_rdata;
    kli_byte_t o_keypad_line_enable;
    kli_addr_t i_sfr_addr = 0;
    int seed = 81971, n_errors = 0, comparisons = 0, r, a, rdm, m[3];
    logic [17:0] want, got;
    always #5 i_clk = ~i_clk;
    kli_keys keys_u (.i_clk, .i_press(press), .o_lines(i_keypad_port));
    kli_top dut_u (.*);
    always @(posedge i_clk)
    begin
        a = 8'(i_sfr_addr - 8'h9c);
        if (i_sfr_rd) rdm = a < 3 ? m[a] : 0;
        // Set after clear, so a same-cycle detection survives the read
        m[2] = (i_sfr_rd && a == 2 ? 0 : m[2]) | ~(i_keypad_port ^ m[0]) & 255;
        if (i_sfr_wr && a < 2) m[a] = i_sfr_wdata;
        if (i_rst) {m[0], m[1], m[2], rdm} = 0;
        r = $random(seed);
        i_rst <= $time < 200 || r[31:24] == 0;
        {i_sfr_wr, i_sfr_rd} <= {r[0], r[1] & !r[0]};
        i_sfr_addr <= 8'h9b + 8'(r[4:2] % 5);
        {i_keypad_global_irq_enable, i_sfr_wdata, press} <= r[24:8];
    end
    always @(negedge i_clk)
    begin
        want = {rdm[7:0], m[1][7:0], |(m[1] & m[2]),
            |(m[1] & m[2]) & i_keypad_global_irq_enable};
        got = {o_sfr_rdata, o_keypad_line_enable, o_wakeup,
            o_keypad_irq_request};
        comparisons += !i_rst;
        if (!i_rst && got !== want)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, want);
        end
    end
    task automatic print_verdict;
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial #30002 print_verdict;
endmodule
